// ### design/i2cms_ctrl.sv
// Two-wire bus controller with master and addressed slave roles.
`include "i2cms_params.svh"
`default_nettype none
module i2cms_ctrl
  import i2cms_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port.
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Bus lines, open drain.
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Requests to the system.
  output logic irq_o,
  output logic dma_rx_req_o,
  output logic dma_tx_req_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [6:0] own_addr;
  logic [7:0] freq, slth, sltl, shift, rxd, cnt, half, rd_mux;
  logic [2:0] up_addr, filt_w;
  logic en, ie, role, dir, txak, dma_en, fack, gce, adext, hto2_ie;
  logic arb_f, if_f, start_f, stop_f, lto_f, hto2_f;
  logic [3:0] bit_cnt;
  logic addr_ph, hold, ack_wait, addressed, slv_tx, busy, rx_ack, tcf, ten_pend;
  logic sda_eng_low, scl_slv_low, scl_drv_low, sda_ctl_low, stop_req, rs_req;
  i2cms_mst_t mstate;
  logic [1:0] sy1, sy2, flt, flt_q;
  logic [2:0] fcnt [2];
  logic [5:0] presc;
  logic [15:0] lo_cnt;
  logic [7:0] hi_cnt;

  function automatic logic hit(input logic s, input logic [3:0] a, input logic [3:0] off);
    return s && (a == off);
  endfunction

  // Decoded strobes and requests from the register port.
  logic ctrl_wr, data_wr, data_rd, go_start, go_stop, go_rs, master_act, xmit;
  assign ctrl_wr = hit(wr_i, addr_i, `I2CMS_R_CTRL);
  assign data_wr = hit(wr_i, addr_i, `I2CMS_R_DATA);
  assign data_rd = hit(rd_i, addr_i, `I2CMS_R_DATA);
  assign go_start = ctrl_wr & wdata_i[`I2CMS_C_MST] & wdata_i[`I2CMS_C_EN] & ~role;
  assign go_stop = ctrl_wr & ~wdata_i[`I2CMS_C_MST] & role;
  assign go_rs = ctrl_wr & wdata_i[`I2CMS_C_RSTA];
  assign master_act = (mstate != M_IDLE);
  // The node only shifts data out in bytes it owns.
  assign xmit = master_act ? (addr_ph | dir) : (addressed & slv_tx & ~addr_ph);

  // ----------------------------------------------------------------
  // Line synchronisers and glitch filters
  // ----------------------------------------------------------------
  logic [1:0] lin;
  assign lin = {sda_i, scl_i};
  genvar g;
  for (g = 0; g < 2; g++) begin : g_line
    // Two flops, then a counter that needs the new level to outlast the width.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        sy1[g] <= 1'b1;
        sy2[g] <= 1'b1;
        flt[g] <= 1'b1;
        flt_q[g] <= 1'b1;
        fcnt[g] <= 3'h0;
      end else begin
        sy1[g] <= lin[g];
        sy2[g] <= sy1[g];
        flt_q[g] <= flt[g];
        if (filt_w == 3'h0 || sy2[g] == flt[g]) begin
          flt[g] <= sy2[g];
          fcnt[g] <= 3'h0;
        end else if (fcnt[g] == filt_w) begin
          flt[g] <= sy2[g];
          fcnt[g] <= 3'h0;
        end else begin
          fcnt[g] <= fcnt[g] + 3'h1;
        end
      end
    end
  end

  // Line events; all but arb_ev are masked while the controller is off.
  logic scl_f, sda_f, scl_rise, scl_fall, start_det, stop_det, ev_done, arb_ev;
  assign scl_f = flt[0];
  assign sda_f = flt[1];
  assign scl_rise = en & busy & scl_f & ~flt_q[0];
  assign scl_fall = en & busy & ~scl_f & flt_q[0];
  assign start_det = en & scl_f & flt_q[0] & ~sda_f & flt_q[1];
  assign stop_det = en & scl_f & flt_q[0] & sda_f & ~flt_q[1];
  assign ev_done = scl_rise & (bit_cnt == `I2CMS_BIT_ACK);
  // Lost when we leave SDA high and read it low, or ask for an illegal start.
  assign arb_ev = (scl_rise & master_act & xmit & (bit_cnt < `I2CMS_BIT_ACK)
                  & ~sda_eng_low & ~sda_ctl_low & ~sda_f)
                  | (go_start & busy) | (go_rs & ~master_act);

  // ----------------------------------------------------------------
  // Slave address matching
  // ----------------------------------------------------------------
  logic rw, m7, mgc, mten1, mten2, addr_match;
  assign rw = shift[0];
  assign m7 = ~adext & (shift[7:1] == own_addr);
  assign mgc = gce & (shift == `I2CMS_GC_ADDR);
  assign mten1 = adext & (shift[7:3] == `I2CMS_TEN_HDR) & (shift[2:1] == up_addr[2:1]);
  assign mten2 = adext & ten_pend & (shift == {up_addr[0], own_addr});
  assign addr_match = ten_pend ? mten2 : (m7 | mgc | (mten1 & (~rw | addressed)));

  // ----------------------------------------------------------------
  // Byte engine, shared by both roles
  // ----------------------------------------------------------------
  // Data changes on SCL falls and is sampled on rises, so our own clock and a
  // remote master's are handled alike.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy <= 1'b0;
      hold <= 1'b0;
      ack_wait <= 1'b0;
      addressed <= 1'b0;
      slv_tx <= 1'b0;
      addr_ph <= 1'b0;
      ten_pend <= 1'b0;
      sda_eng_low <= 1'b0;
      bit_cnt <= `I2CMS_BIT_END;
      tcf <= 1'b1;
      rx_ack <= 1'b0;
      shift <= 8'h00;
      rxd <= 8'h00;
    end else if (!en || stop_det) begin
      busy <= 1'b0;
      hold <= 1'b0;
      ack_wait <= 1'b0;
      addressed <= 1'b0;
      slv_tx <= 1'b0;
      addr_ph <= 1'b0;
      ten_pend <= 1'b0;
      sda_eng_low <= 1'b0;
      bit_cnt <= `I2CMS_BIT_END;
      tcf <= 1'b1;
    end else if (start_det) begin
      busy <= 1'b1;
      bit_cnt <= 4'h0;
      addr_ph <= 1'b1;
      ten_pend <= 1'b0;
      ack_wait <= 1'b0;
      hold <= (mstate == M_START);
      sda_eng_low <= 1'b0;
    end else begin
      if (arb_ev) begin
        sda_eng_low <= 1'b0;
      end else if (scl_fall) begin
        if (bit_cnt < `I2CMS_BIT_ACK) begin
          sda_eng_low <= xmit & ~shift[7];
        end else if (bit_cnt == `I2CMS_BIT_ACK) begin
          if (xmit) begin
            sda_eng_low <= 1'b0;
          end else if (addr_ph) begin
            sda_eng_low <= ~master_act & addr_match;
          end else if (fack && (master_act || addressed)) begin
            ack_wait <= 1'b1;
            hold <= 1'b1;
            sda_eng_low <= 1'b0;
          end else begin
            sda_eng_low <= (master_act | addressed) & ~txak;
          end
        end else begin
          sda_eng_low <= 1'b0;
          bit_cnt <= 4'h0;
        end
      end
      if (scl_rise && bit_cnt < `I2CMS_BIT_ACK) begin
        shift <= {shift[6:0], sda_f};
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == 4'h0) begin
          tcf <= 1'b0;
        end
      end
      if (ev_done) begin
        rx_ack <= sda_f;
        bit_cnt <= `I2CMS_BIT_END;
        tcf <= 1'b1;
        if (master_act) begin
          addr_ph <= 1'b0;
          hold <= 1'b1;
          if (!xmit) begin
            rxd <= shift;
          end
        end else if (addr_ph) begin
          rxd <= shift;
          if (ten_pend) begin
            ten_pend <= 1'b0;
            addr_ph <= 1'b0;
            addressed <= mten2;
            slv_tx <= 1'b0;
          end else if (mten1 && !rw) begin
            ten_pend <= 1'b1;
          end else begin
            addr_ph <= 1'b0;
            addressed <= addr_match;
            slv_tx <= addr_match & rw;
            hold <= addr_match & rw;
          end
        end else if (addressed) begin
          if (slv_tx) begin
            // A refused byte ends our part in the transfer.
            hold <= ~sda_f;
            addressed <= ~sda_f;
          end else begin
            rxd <= shift;
          end
        end
      end
      if (data_wr && hold && !ack_wait && xmit) begin
        shift <= wdata_i;
        sda_eng_low <= ~wdata_i[7];
        hold <= 1'b0;
      end
      if (data_rd && hold && !ack_wait && master_act && !xmit) begin
        hold <= 1'b0;
      end
      if (ctrl_wr && ack_wait) begin
        ack_wait <= 1'b0;
        hold <= 1'b0;
        sda_eng_low <= ~wdata_i[`I2CMS_C_TXAK];
      end
    end
  end

  // Slave clock stretch while software owes a byte or an ack decision.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_slv_low <= 1'b0;
    end else begin
      scl_slv_low <= en & ~master_act & hold & ~scl_f;
    end
  end

  // ----------------------------------------------------------------
  // Master sequencer and clock generator
  // ----------------------------------------------------------------
  assign half = (freq < `I2CMS_MIN_HALF) ? `I2CMS_MIN_HALF : freq;

  // The high phase counts only while the line reads high, which keeps
  // us in step with slower masters and stretching slaves.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mstate <= M_IDLE;
      scl_drv_low <= 1'b0;
      sda_ctl_low <= 1'b0;
      cnt <= 8'h00;
      stop_req <= 1'b0;
      rs_req <= 1'b0;
    end else if (!en || arb_ev) begin
      mstate <= M_IDLE;
      scl_drv_low <= 1'b0;
      sda_ctl_low <= 1'b0;
      cnt <= 8'h00;
      stop_req <= 1'b0;
      rs_req <= 1'b0;
    end else begin
      if (go_stop && master_act) begin
        stop_req <= 1'b1;
      end
      if (go_rs && master_act) begin
        rs_req <= 1'b1;
      end
      unique case (mstate)
        M_IDLE: begin
          scl_drv_low <= 1'b0;
          sda_ctl_low <= 1'b0;
          cnt <= 8'h00;
          if (go_start && !busy) begin
            sda_ctl_low <= 1'b1;
            mstate <= M_START;
          end
        end
        M_START: begin
          if (scl_f) begin
            cnt <= cnt + 8'h01;
          end
          if (cnt >= half) begin
            scl_drv_low <= 1'b1;
            cnt <= 8'h00;
            mstate <= M_RUN;
          end
        end
        M_RUN: begin
          if (scl_drv_low && !scl_f) begin
            sda_ctl_low <= 1'b0;
          end
          if (scl_drv_low) begin
            if (hold) begin
              cnt <= 8'h00;
              if (stop_req && !ack_wait) begin
                stop_req <= 1'b0;
                sda_ctl_low <= 1'b1;
                mstate <= M_STOP;
              end else if (rs_req && !ack_wait) begin
                rs_req <= 1'b0;
                mstate <= M_RS;
              end
            end else if (cnt >= half) begin
              scl_drv_low <= 1'b0;
              cnt <= 8'h00;
            end else begin
              cnt <= cnt + 8'h01;
            end
          end else if (!scl_f) begin
            cnt <= 8'h00;
          end else if (cnt >= half) begin
            scl_drv_low <= 1'b1;
            cnt <= 8'h00;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        M_STOP: begin
          cnt <= cnt + 8'h01;
          if (cnt >= half) begin
            scl_drv_low <= 1'b0;
            cnt <= 8'h00;
            mstate <= M_STOP2;
          end
        end
        M_STOP2: begin
          if (scl_f) begin
            cnt <= cnt + 8'h01;
          end
          if (cnt >= half) begin
            sda_ctl_low <= 1'b0;
            cnt <= 8'h00;
            mstate <= M_IDLE;
          end
        end
        M_RS: begin
          sda_ctl_low <= 1'b0;
          cnt <= cnt + 8'h01;
          if (cnt >= half) begin
            scl_drv_low <= 1'b0;
            cnt <= 8'h00;
            mstate <= M_RS2;
          end
        end
        M_RS2: begin
          if (scl_f) begin
            cnt <= cnt + 8'h01;
          end
          if (cnt >= half) begin
            sda_ctl_low <= 1'b1;
            cnt <= 8'h00;
            mstate <= M_START;
          end
        end
      endcase
    end
  end

  // Open drain: the level driven is always low.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = en & (scl_drv_low | scl_slv_low);
  assign sda_oe_o = en & (sda_ctl_low | sda_eng_low);

  // ----------------------------------------------------------------
  // Timeouts
  // ----------------------------------------------------------------
  logic tick, lto_hit, hto, hto2_hit;
  logic [15:0] lo_lim;
  assign tick = (presc == `I2CMS_TO_PRESC);
  assign lo_lim = {slth, sltl};
  assign lto_hit = en & ~scl_f & (lo_cnt == lo_lim) & (lo_lim != 16'h0000);
  assign hto = en & busy & (hi_cnt == `I2CMS_HTO_TICKS) & sda_f;
  assign hto2_hit = en & busy & (hi_cnt == `I2CMS_HTO_TICKS) & ~sda_f;

  // Counts run in prescaled ticks so a 16-bit limit spans long stalls.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      presc <= 6'h00;
      lo_cnt <= 16'h0000;
      hi_cnt <= 8'h00;
    end else begin
      presc <= presc + 6'h01;
      if (!en || scl_f) begin
        lo_cnt <= 16'h0000;
      end else if (tick && lo_cnt != lo_lim) begin
        lo_cnt <= lo_cnt + 16'h0001;
      end
      if (!en || !scl_f || flt[1] != flt_q[1]) begin
        hi_cnt <= 8'h00;
      end else if (tick && hi_cnt != `I2CMS_HTO_TICKS) begin
        hi_cnt <= hi_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers and sticky flags
  // ----------------------------------------------------------------
  logic stat_wr, filt_wr, smb_wr, ev_if;
  assign stat_wr = hit(wr_i, addr_i, `I2CMS_R_STAT);
  assign filt_wr = hit(wr_i, addr_i, `I2CMS_R_FILT);
  assign smb_wr = hit(wr_i, addr_i, `I2CMS_R_SMB);
  assign ev_if = (ev_done & (master_act | addressed | (addr_ph & addr_match))) | arb_ev;

  // Configuration; a lost arbitration takes the master role away.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {en, ie, role, dir, txak, dma_en, fack} <= 7'h00;
      {gce, adext, hto2_ie} <= 3'h0;
      own_addr <= 7'h00;
      up_addr <= 3'h0;
      filt_w <= 3'h0;
      freq <= `I2CMS_RST_FREQ;
      slth <= 8'h00;
      sltl <= 8'h00;
    end else begin
      if (ctrl_wr) begin
        en <= wdata_i[`I2CMS_C_EN];
        ie <= wdata_i[`I2CMS_C_IE];
        role <= wdata_i[`I2CMS_C_MST];
        dir <= wdata_i[`I2CMS_C_TX];
        txak <= wdata_i[`I2CMS_C_TXAK];
        dma_en <= wdata_i[`I2CMS_C_DMA];
        fack <= wdata_i[`I2CMS_C_FACK];
      end
      if (arb_ev || !master_act && mstate == M_IDLE && role && !go_start && !ctrl_wr
          && !busy && 1'b0) begin
        role <= 1'b0;
      end
      if (arb_ev) begin
        role <= 1'b0;
      end
      if (hit(wr_i, addr_i, `I2CMS_R_ADDR)) begin
        own_addr <= wdata_i[6:0];
      end
      if (hit(wr_i, addr_i, `I2CMS_R_CTRL2)) begin
        gce <= wdata_i[`I2CMS_C2_GCE];
        adext <= wdata_i[`I2CMS_C2_ADEXT];
        up_addr <= wdata_i[2:0];
      end
      if (filt_wr) begin
        filt_w <= wdata_i[2:0];
      end
      if (smb_wr) begin
        hto2_ie <= wdata_i[`I2CMS_T_HTO2IE];
      end
      if (hit(wr_i, addr_i, `I2CMS_R_FREQ)) begin
        freq <= wdata_i;
      end
      if (hit(wr_i, addr_i, `I2CMS_R_SLTH)) begin
        slth <= wdata_i;
      end
      if (hit(wr_i, addr_i, `I2CMS_R_SLTL)) begin
        sltl <= wdata_i;
      end
    end
  end

  // Sticky flags clear by writing one; a new event in the same cycle wins.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {arb_f, if_f, start_f, stop_f, lto_f, hto2_f} <= 6'h00;
    end else begin
      arb_f <= arb_ev | (arb_f & ~(stat_wr & wdata_i[`I2CMS_S_ARB]));
      if_f <= ev_if | (if_f & ~(stat_wr & wdata_i[`I2CMS_S_IF]));
      start_f <= start_det | (start_f & ~(filt_wr & wdata_i[`I2CMS_F_START]));
      stop_f <= stop_det | (stop_f & ~(filt_wr & wdata_i[`I2CMS_F_STOP]));
      lto_f <= lto_hit | (lto_f & ~(smb_wr & wdata_i[`I2CMS_T_LTO]));
      hto2_f <= hto2_hit | (hto2_f & ~(smb_wr & wdata_i[`I2CMS_T_HTO2]));
    end
  end

  // Read data mux; unmapped offsets read zero.
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr_i)
      `I2CMS_R_ADDR: rd_mux[6:0] = own_addr;
      `I2CMS_R_FREQ: rd_mux = freq;
      `I2CMS_R_CTRL: rd_mux = {en, ie, role, dir, txak, 1'b0, dma_en, fack};
      `I2CMS_R_STAT: begin
        rd_mux[`I2CMS_S_TCF] = tcf;
        rd_mux[`I2CMS_S_AAS] = addressed;
        rd_mux[`I2CMS_S_BUSY] = busy;
        rd_mux[`I2CMS_S_ARB] = arb_f;
        rd_mux[`I2CMS_S_SRW] = slv_tx;
        rd_mux[`I2CMS_S_IF] = if_f;
        rd_mux[`I2CMS_S_RXAK] = rx_ack;
      end
      `I2CMS_R_DATA: rd_mux = rxd;
      `I2CMS_R_CTRL2: begin
        rd_mux[`I2CMS_C2_GCE] = gce;
        rd_mux[`I2CMS_C2_ADEXT] = adext;
        rd_mux[2:0] = up_addr;
      end
      `I2CMS_R_FILT: begin
        rd_mux[`I2CMS_F_STOP] = stop_f;
        rd_mux[`I2CMS_F_START] = start_f;
        rd_mux[2:0] = filt_w;
      end
      `I2CMS_R_SMB: begin
        rd_mux[`I2CMS_T_LTO] = lto_f;
        rd_mux[`I2CMS_T_HTO] = hto;
        rd_mux[`I2CMS_T_HTO2] = hto2_f;
        rd_mux[`I2CMS_T_HTO2IE] = hto2_ie;
      end
      `I2CMS_R_SLTH: rd_mux = slth;
      `I2CMS_R_SLTL: rd_mux = sltl;
      default: rd_mux = 8'h00;
    endcase
  end

  // Registered outputs: read data, interrupt and DMA pulses.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
      irq_o <= 1'b0;
      dma_rx_req_o <= 1'b0;
      dma_tx_req_o <= 1'b0;
    end else begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
      irq_o <= (ie & if_f) | (hto2_ie & hto2_f);
      // Fast ack asks for the received byte before its ack, not after.
      dma_rx_req_o <= dma_en & ~xmit & ~addr_ph & (master_act | addressed)
                      & (fack ? (scl_fall & (bit_cnt == `I2CMS_BIT_ACK))
                              : ev_done);
      dma_tx_req_o <= dma_en & ((xmit & (fack ? (scl_rise & (bit_cnt == 4'h7))
                                              : (ev_done & ~sda_f)))
                      | (ev_done & ~master_act & addr_ph & ~ten_pend & addr_match & rw));
    end
  end

endmodule
`default_nettype wire

// ### design/i2cms_params.svh
// Register offsets, field positions, reset values and timing counts of the two-wire controller.
`ifndef I2CMS_PARAMS_SVH
`define I2CMS_PARAMS_SVH
// Register offsets.
`define I2CMS_R_ADDR 4'h0
`define I2CMS_R_FREQ 4'h1
`define I2CMS_R_CTRL 4'h2
`define I2CMS_R_STAT 4'h3
`define I2CMS_R_DATA 4'h4
`define I2CMS_R_CTRL2 4'h5
`define I2CMS_R_FILT 4'h6
`define I2CMS_R_SMB 4'h7
`define I2CMS_R_SLTH 4'h8
`define I2CMS_R_SLTL 4'h9
// Control register fields.
`define I2CMS_C_EN 7
`define I2CMS_C_IE 6
`define I2CMS_C_MST 5
`define I2CMS_C_TX 4
`define I2CMS_C_TXAK 3
`define I2CMS_C_RSTA 2
`define I2CMS_C_DMA 1
`define I2CMS_C_FACK 0
// Status register fields.
`define I2CMS_S_TCF 7
`define I2CMS_S_AAS 6
`define I2CMS_S_BUSY 5
`define I2CMS_S_ARB 4
`define I2CMS_S_SRW 2
`define I2CMS_S_IF 1
`define I2CMS_S_RXAK 0
// Second control, filter and timeout register fields.
`define I2CMS_C2_GCE 7
`define I2CMS_C2_ADEXT 6
`define I2CMS_F_STOP 6
`define I2CMS_F_START 5
`define I2CMS_T_LTO 3
`define I2CMS_T_HTO 2
`define I2CMS_T_HTO2 1
`define I2CMS_T_HTO2IE 0
// Reset values and timing.
`define I2CMS_RST_FREQ 8'hC8
`define I2CMS_MIN_HALF 8'h0A
`define I2CMS_TO_PRESC 6'h3F
`define I2CMS_HTO_TICKS 8'h32
`define I2CMS_TEN_HDR 5'h1E
`define I2CMS_GC_ADDR 8'h00
`define I2CMS_BIT_ACK 4'h8
`define I2CMS_BIT_END 4'h9
`endif

// ### design/i2cms_pkg.sv
// Types shared by the two-wire controller.
`default_nettype none
package i2cms_pkg;
  // Master sequencer states, one-hot.
  typedef enum logic [6:0] {
    M_IDLE  = 7'h01,
    M_START = 7'h02,
    M_RUN   = 7'h04,
    M_STOP  = 7'h08,
    M_STOP2 = 7'h10,
    M_RS    = 7'h20,
    M_RS2   = 7'h40
  } i2cms_mst_t;
endpackage
`default_nettype wire

// ### tb/i2cms_asserts.sv
// Port-level checker for the two-wire controller.
`include "i2cms_params.svh"
`default_nettype none
module i2cms_asserts (
  // Watched ports.
  input wire logic clk_i, arst_n_i, wr_i, rd_i, scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i, rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic en, ie, hie;
  // Shadow copies of the enables, since the checker sees no internal state.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {en, ie, hie} <= 3'h0;
    end else if (wr_i && addr_i == `I2CMS_R_CTRL) begin
      {en, ie} <= wdata_i[7:6];
    end else if (wr_i && addr_i == `I2CMS_R_SMB) begin
      hie <= wdata_i[0];
    end
  end
  chk_off_quiet: assert property (!en |-> !scl_oe_o && !sda_oe_o)
    else $error("bus pulled while disabled");
  chk_open_drain: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  chk_irq_gate: assert property (!ie && !hie |=> !irq_o)
    else $error("request while masked");
  chk_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  chk_unmapped_zero: assert property (rd_i && addr_i > `I2CMS_R_SLTL |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_rsta_reads0: assert property (rd_i && addr_i == `I2CMS_R_CTRL |=> !rdata_o[2])
    else $error("restart request reads back");
  chk_ctrl_echo: assert property (wr_i && addr_i == `I2CMS_R_CTRL ##1 rd_i &&
    addr_i == `I2CMS_R_CTRL |=> (rdata_o & 8'hDB) == ($past(wdata_i, 2) & 8'hDB))
    else $error("control readback differs");
  chk_slt_echo: assert property (wr_i && addr_i inside {`I2CMS_R_SLTH, `I2CMS_R_SLTL} ##1
    rd_i && addr_i == $past(addr_i) |=> rdata_o == $past(wdata_i, 2))
    else $error("timeout byte readback differs");
  cover property (irq_o);
  cover property (wr_i && addr_i == `I2CMS_R_FILT);
  cover property (rd_i && addr_i == `I2CMS_R_STAT);
endmodule
bind i2cms_ctrl i2cms_asserts u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .wr_i(wr_i),
  .rd_i(rd_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .irq_o(irq_o), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o));
`default_nettype wire

// ### tb/i2cms_peer.sv
// Second bus node: pull-up resolved lines that it can also pull low.
`default_nettype none
module i2cms_peer (
  // Pull requests of the controller and of this node.
  input wire logic dut_scl_oe_i, dut_sda_oe_i, pull_scl_i, pull_sda_i,
  // Resolved line levels.
  output logic scl_o, sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Wired-AND: a released line returns to the pull-up level, never a stale value.
  assign scl_o = !(dut_scl_oe_i || pull_scl_i);
  assign sda_o = !(dut_sda_oe_i || pull_sda_i);
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the two-wire controller.
`include "i2cms_params.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0, p_scl = 0, p_sda = 0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, q;
  logic scl, sda, scl_oe, sda_oe, irq_o;
  int n_fail = 0, cmp_count = 0;
  i2cms_ctrl dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
    .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .irq_o(irq_o), .dma_rx_req_o(), .dma_tx_req_o());
  i2cms_peer peer (.dut_scl_oe_i(scl_oe), .dut_sda_oe_i(sda_oe), .pull_scl_i(p_scl),
    .pull_sda_i(p_sda), .scl_o(scl), .sda_o(sda));
  // 40 MHz module clock.
  initial forever #12.5 clk_i = ~clk_i;
  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Tasks start just after an edge, so a write may be followed by a read with no gap.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    cyc(1);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    rd_i <= 1'b1;
    addr_i <= a;
    cyc(1);
    rd_i <= 1'b0;
    // Read data stand for one cycle only; take them mid-cycle, then realign to an edge.
    @(negedge clk_i) q = rdata_o;
    @(posedge clk_i);
  endtask
  // Start when dn is set, stop otherwise; line changes wait out sync and filter.
  task automatic sda_to(input logic dn);
    p_sda <= dn;
    cyc(20);
  endtask
  task automatic t_regs;
    rd(`I2CMS_R_FREQ);
    chk("freq", q, `I2CMS_RST_FREQ);
    rd(4'hF);
    chk("unmapped", q, 8'h00);
    wr(`I2CMS_R_SLTH, 8'hA5);
    rd(`I2CMS_R_SLTH);
    chk("slth", q, 8'hA5);
    wr(`I2CMS_R_SLTL, 8'h5A);
    rd(`I2CMS_R_SLTL);
    chk("sltl", q, 8'h5A);
    wr(`I2CMS_R_CTRL, 8'h10);
    rd(`I2CMS_R_CTRL);
    chk("dir", q, 8'h10);
  endtask
  task automatic t_arb;
    wr(`I2CMS_R_CTRL, 8'h84);
    cyc(25);
    rd(`I2CMS_R_STAT);
    chk("arb", q & 8'h32, 8'h12);
    wr(`I2CMS_R_CTRL, 8'hC0);
    cyc(3);
    chk("irq", {7'h0, irq_o}, 8'h01);
    wr(`I2CMS_R_STAT, 8'h12);
    cyc(3);
    rd(`I2CMS_R_STAT);
    chk("arbclr", q & 8'h12, 8'h00);
    chk("irqclr", {7'h0, irq_o}, 8'h00);
  endtask
  task automatic t_bus(input logic on);
    wr(`I2CMS_R_CTRL, {on, 7'h00});
    cyc(1);
    wr(`I2CMS_R_FILT, 8'h03);
    p_sda <= 1'b1;
    cyc(2);
    sda_to(1'b0);
    rd(`I2CMS_R_FILT);
    chk("glitch", q, 8'h03);
    sda_to(1'b1);
    rd(`I2CMS_R_STAT);
    chk("busy", q & 8'h20, {2'h0, on, 5'h0});
    sda_to(1'b0);
    rd(`I2CMS_R_FILT);
    chk("flags", q, {1'b0, on, on, 5'h03});
    wr(`I2CMS_R_FILT, 8'h63);
    rd(`I2CMS_R_FILT);
    chk("flagclr", q, 8'h03);
  endtask
  // Master start, one unanswered address byte, then stop; the stop must not
  // look like a lost arbitration even with transmit still selected.
  task automatic t_mst;
    wr(`I2CMS_R_CTRL, 8'h80);
    cyc(1);
    wr(`I2CMS_R_CTRL, 8'hB0);
    cyc(300);
    chk("sclhold", {7'h0, scl_oe}, 8'h01);
    rd(`I2CMS_R_STAT);
    chk("mbusy", q & 8'h20, 8'h20);
    wr(`I2CMS_R_DATA, 8'hA0);
    cyc(4000);
    rd(`I2CMS_R_STAT);
    chk("mdone", q, 8'hA3);
    wr(`I2CMS_R_CTRL, 8'h90);
    cyc(600);
    rd(`I2CMS_R_STAT);
    chk("mstop", q & 8'h30, 8'h00);
    chk("release", {6'h0, scl_oe, sda_oe}, 8'h00);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The tests need under 6000 cycles; 40000 cycles without a verdict means a hang.
  initial begin
    #1000000;
    n_fail++;
    end_sim();
  end
  initial begin
    cyc(6);
    arst_n_i <= 1'b1;
    cyc(1);
    t_regs();
    t_arb();
    t_bus(1'b1);
    t_bus(1'b0);
    t_mst();
    end_sim();
  end
endmodule
`default_nettype wire
